//--- rtl/sll_pkg.sv
// constants and types for the status lamp and learning sequencer
package sll_pkg;

	// ------------------------------------------------------------
	// clock and base tick
	// ------------------------------------------------------------
	localparam int CLK_HZ       = 200_000_000; // core clock rate
	localparam int MS_PER_S     = 1000;        // milliseconds per second
	localparam int MS_CYCLES    = CLK_HZ / MS_PER_S; // cycles per ms tick
	localparam int TICK_W       = 18;          // ms divider width

	// ------------------------------------------------------------
	// lamp timing, in milliseconds
	// ------------------------------------------------------------
	localparam int SLOW_PERIOD_MS  = 2000;     // 0.5 Hz blink period
	localparam int FAST_PERIOD_MS  = 500;      // 2 Hz blink period
	localparam int LEARN_HALF_MS   = 250;      // one half of a result flash
	localparam int HOLD_MS         = 1000;     // both lamps lit after success
	localparam int MS_W            = 11;       // ms counter width

	localparam logic [MS_W-1:0] SLOW_LAST  = MS_W'(SLOW_PERIOD_MS - 1);
	localparam logic [MS_W-1:0] SLOW_HALF  = MS_W'(SLOW_PERIOD_MS / 2);
	localparam logic [MS_W-1:0] FAST_PER   = MS_W'(FAST_PERIOD_MS);
	localparam logic [MS_W-1:0] FAST_HALF  = MS_W'(FAST_PERIOD_MS / 2);
	localparam logic [MS_W-1:0] LEARN_LAST = MS_W'(LEARN_HALF_MS - 1);
	localparam logic [MS_W-1:0] HOLD_LAST  = MS_W'(HOLD_MS - 1);

	// ------------------------------------------------------------
	// flash counts, counted in half phases
	// ------------------------------------------------------------
	localparam int ALT_FLASHES  = 6;           // alternate flashes
	localparam int FAIL_FLASHES = 3;           // yellow flashes on failure
	localparam logic [3:0] ALT_LAST  = 4'(2 * ALT_FLASHES - 1);
	localparam logic [3:0] FAIL_LAST = 4'(2 * FAIL_FLASHES - 1);

	// ------------------------------------------------------------
	// pushbutton timing, in milliseconds
	// ------------------------------------------------------------
	localparam int DEBOUNCE_MS  = 20;          // contact bounce filter
	localparam int LONG_MS      = 1000;        // hold for bus mode
	localparam logic [MS_W-1:0] DEBOUNCE_LAST = MS_W'(DEBOUNCE_MS - 1);
	localparam logic [MS_W-1:0] LONG_CNT      = MS_W'(LONG_MS);

	// ------------------------------------------------------------
	// input schemes and sequence states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SCH_POS,                               // pulse position control
		SCH_DOUBLE,                            // preset speed, double key
		SCH_SINGLE,                            // preset speed, single touch
		SCH_NONE                               // inputs unused
	} sll_scheme_t;

	typedef enum logic [1:0] {
		SEQ_IDLE,                              // normal indication
		SEQ_ALT,                               // alternate flashing
		SEQ_HOLD,                              // both lit after success
		SEQ_FAIL                               // yellow flashes after failure
	} sll_seq_t;

endpackage : sll_pkg

//--- rtl/sll_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps

module sll_sync #(
	parameter int W = 1                        // number of bits
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] asyncIn,         // raw pin levels
	output logic      [W-1:0] syncOut          // safe to read
);

	logic [W-1:0] meta_r;                      // first stage, read only below
	logic [W-1:0] sync_r;                      // second stage

	// ------------------------------------------------------------
	// two flops; nothing but the second stage reads the first
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= asyncIn;
			sync_r <= meta_r;
		end
	end

	assign syncOut = sync_r;

endmodule : sll_sync

//--- rtl/sll_status_led.sv
// status lamps, pushbutton and discrete input mapping of the drive
//
// Function
// R1: normal operation: green blinks at 0.5 Hz
// R2: communicating: green blinks at 2 Hz
// R3: signal control mode: yellow steadily lit
// R4: bus control mode: yellow kept dark
// R5: fault: only yellow flashes
// R6: learn success: six alternates, both lit 1s
// R7: learn failure: six alternates, three yellow flashes
// R8: short button press starts phase learning
// R9: one second hold then release: bus mode
// R10: double key: forward, reverse, stop, status out
// R11: single touch: inputs step direction, third stops
// R12: pulse position: step, direction, emergency stop, done
// R13: result sequence overrides normal lamp patterns
`timescale 1ns/10ps

module sll_status_led #(
	parameter int MS_TICK_CYCLES = sll_pkg::MS_CYCLES // cycles per ms
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 buttonPin,   // pressed = high
	input  wire logic [2:0]           ctrlPin,     // discrete inputs 1..3
	input  wire sll_pkg::sll_scheme_t scheme,      // input scheme
	input  wire logic                 commActive,  // bus traffic seen
	input  wire logic                 faultActive, // drive fault
	input  wire logic                 moveDone,    // positioning done
	input  wire logic                 learnDone,   // learning finished
	input  wire logic                 learnOk,     // with learnDone
	output logic                      greenLed,    // green lamp on
	output logic                      yellowLed,   // yellow lamp on
	output logic                      learnStart,  // start learning
	output logic                      busMode,     // bus control mode
	output logic                      runEnable,   // motor run
	output logic                      runReverse,  // reverse direction
	output logic                      stepPulse,   // one step
	output logic                      stepDir,     // step direction
	output logic                      eStop,       // emergency stop
	output logic                      statusOut    // fault/completion
);

	// ------------------------------------------------------------
	// input synchronisers and ms tick
	// ------------------------------------------------------------
	logic [3:0]              pinSync;          // button + inputs
	logic [2:0]              in_r;             // previous input levels
	logic [2:0]              inRise;           // input activations
	logic [sll_pkg::TICK_W-1:0] tick_r;        // ms divider
	logic [sll_pkg::TICK_W-1:0] tick_nxt;
	logic                    msTick;           // one-cycle ms enable

	sll_sync #(.W(4)) uSync (
		.clk     (clk),
		.rst     (rst),
		.asyncIn ({buttonPin, ctrlPin}),
		.syncOut (pinSync)
	);

	assign inRise = pinSync[2:0] & ~in_r;
	assign msTick = (tick_r == sll_pkg::TICK_W'(MS_TICK_CYCLES - 1));

	// divider wraps every ms
	always_comb begin
		tick_nxt = msTick ? '0 : tick_r + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tick_r <= '0;
			in_r   <= '0;
		end else begin
			tick_r <= tick_nxt;
			in_r   <= pinSync[2:0];
		end
	end

	// ------------------------------------------------------------
	// blink phase generator
	// ------------------------------------------------------------
	logic [sll_pkg::MS_W-1:0] blink_r;         // ms within slow period
	logic [sll_pkg::MS_W-1:0] blink_nxt;
	logic                     slowPh;          // 0.5 Hz phase
	logic                     fastPh;          // 2 Hz phase

	assign slowPh = blink_r < sll_pkg::SLOW_HALF;
	assign fastPh = (blink_r % sll_pkg::FAST_PER) < sll_pkg::FAST_HALF;

	// fast period divides the slow one, so both stay in step
	always_comb begin
		blink_nxt = blink_r;
		if (msTick) begin
			blink_nxt = (blink_r == sll_pkg::SLOW_LAST) ? '0
			            : blink_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) blink_r <= '0;
		else     blink_r <= blink_nxt;
	end

	// ------------------------------------------------------------
	// pushbutton: debounce, hold timing, press decode
	// ------------------------------------------------------------
	logic                     btn_r, btn_nxt;  // debounced level
	logic [sll_pkg::MS_W-1:0] db_r, db_nxt;    // bounce filter count
	logic [sll_pkg::MS_W-1:0] hold_r, hold_nxt; // ms held, saturating
	logic                     learnStart_r, learnStart_nxt;
	logic                     busMode_r, busMode_nxt;
	logic                     btnFall;         // debounced release
	logic                     longHeld;        // held a full second

	assign longHeld = (hold_r >= sll_pkg::LONG_CNT);
	assign btnFall  = msTick && btn_r && !pinSync[3]
	                  && (db_r == sll_pkg::DEBOUNCE_LAST);

	// release decides the kind of press, so a long hold never learns
	always_comb begin
		btn_nxt        = btn_r;
		db_nxt         = db_r;
		hold_nxt       = hold_r;
		learnStart_nxt = 1'b0;
		busMode_nxt    = busMode_r;
		if (msTick) begin
			if (pinSync[3] == btn_r) begin
				db_nxt = '0;
			end else if (db_r == sll_pkg::DEBOUNCE_LAST) begin
				db_nxt  = '0;
				btn_nxt = pinSync[3];
			end else begin
				db_nxt = db_r + 1'b1;
			end
			if (btn_r && !longHeld) hold_nxt = hold_r + 1'b1;
		end
		if (btnFall) begin
			hold_nxt = '0;
			if (longHeld) busMode_nxt = 1'b1;    // [R9]
			else          learnStart_nxt = 1'b1; // [R8]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			btn_r        <= 1'b0;
			db_r         <= '0;
			hold_r       <= '0;
			learnStart_r <= 1'b0;
			busMode_r    <= 1'b0;
		end else begin
			btn_r        <= btn_nxt;
			db_r         <= db_nxt;
			hold_r       <= hold_nxt;
			learnStart_r <= learnStart_nxt;
			busMode_r    <= busMode_nxt;
		end
	end

	// ------------------------------------------------------------
	// learning result sequence and lamp drive
	// ------------------------------------------------------------
	sll_pkg::sll_seq_t        seq_r, seq_nxt;
	logic [sll_pkg::MS_W-1:0] seqMs_r, seqMs_nxt;  // ms in half phase, or in the hold
	logic [3:0]               half_r, half_nxt;    // half phase index
	logic                     ok_r, ok_nxt;        // learning outcome
	logic                     green_r, green_nxt;
	logic                     yellow_r, yellow_nxt;
	logic                     halfEnd;             // half phase done

	assign halfEnd = msTick && (seqMs_r == sll_pkg::LEARN_LAST);

	// sequence steps on ms ticks; normal patterns wait behind it
	always_comb begin
		seq_nxt   = seq_r;
		seqMs_nxt = seqMs_r;
		half_nxt  = half_r;
		ok_nxt    = ok_r;
		if (msTick) seqMs_nxt = seqMs_r + 1'b1;
		case (seq_r)
			sll_pkg::SEQ_IDLE: begin
				seqMs_nxt = '0;
				half_nxt  = '0;
				if (learnDone) begin
					seq_nxt = sll_pkg::SEQ_ALT;
					ok_nxt  = learnOk;
				end
			end
			sll_pkg::SEQ_ALT: begin
				if (halfEnd) begin
					seqMs_nxt = '0;
					half_nxt  = half_r + 1'b1;
					if (half_r == sll_pkg::ALT_LAST) begin
						half_nxt = '0;
						seq_nxt  = ok_r ? sll_pkg::SEQ_HOLD // [R6]
						                : sll_pkg::SEQ_FAIL; // [R7]
					end
				end
			end
			sll_pkg::SEQ_HOLD: begin
				if (msTick && seqMs_r == sll_pkg::HOLD_LAST) begin
					seq_nxt = sll_pkg::SEQ_IDLE; // [R6]
				end
			end
			sll_pkg::SEQ_FAIL: begin
				if (halfEnd) begin
					seqMs_nxt = '0;
					half_nxt  = half_r + 1'b1;
					if (half_r == sll_pkg::FAIL_LAST) begin
						seq_nxt = sll_pkg::SEQ_IDLE; // [R7]
					end
				end
			end
			default: seq_nxt = sll_pkg::SEQ_IDLE;
		endcase
	end

	// lamp choice; priority is sequence, then fault, then mode
	always_comb begin
		green_nxt  = 1'b0;
		yellow_nxt = 1'b0;
		case (seq_r)
			sll_pkg::SEQ_ALT: begin
				green_nxt  = !half_r[0];            // [R6] [R7] [R13]
				yellow_nxt = half_r[0];
			end
			sll_pkg::SEQ_HOLD: begin
				green_nxt  = 1'b1;                  // [R6] [R13]
				yellow_nxt = 1'b1;
			end
			sll_pkg::SEQ_FAIL: begin
				yellow_nxt = !half_r[0];            // [R7] [R13]
			end
			default: begin
				if (faultActive) begin
					yellow_nxt = slowPh;            // [R5]
				end else begin
					green_nxt  = commActive ? fastPh // [R2]
					                        : slowPh; // [R1]
					yellow_nxt = !busMode_r;        // [R3] [R4]
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			seq_r    <= sll_pkg::SEQ_IDLE;
			seqMs_r  <= '0;
			half_r   <= '0;
			ok_r     <= 1'b0;
			green_r  <= 1'b0;
			yellow_r <= 1'b0;
		end else begin
			seq_r    <= seq_nxt;
			seqMs_r  <= seqMs_nxt;
			half_r   <= half_nxt;
			ok_r     <= ok_nxt;
			green_r  <= green_nxt;
			yellow_r <= yellow_nxt;
		end
	end

	// ------------------------------------------------------------
	// discrete input schemes
	// ------------------------------------------------------------
	logic run_r, run_nxt;                        // motor running
	logic rev_r, rev_nxt;                        // reverse selected
	logic step_r, step_nxt;                      // step pulse
	logic dir_r, dir_nxt;                        // step direction
	logic stop_r, stop_nxt;                      // emergency stop
	logic stat_r, stat_nxt;                      // fault/completion

	// stop input always wins over a run request in the same cycle
	always_comb begin
		run_nxt  = run_r;
		rev_nxt  = rev_r;
		step_nxt = 1'b0;
		dir_nxt  = dir_r;
		stop_nxt = 1'b0;
		stat_nxt = faultActive || moveDone;      // [R10] [R12]
		case (scheme)
			sll_pkg::SCH_POS: begin
				run_nxt  = 1'b0;
				dir_nxt  = pinSync[1];              // [R12]
				stop_nxt = pinSync[2];              // [R12]
				step_nxt = inRise[0] && !pinSync[2]; // [R12]
			end
			sll_pkg::SCH_DOUBLE: begin
				if (inRise[2]) begin
					run_nxt = 1'b0;                 // [R10]
				end else if (inRise[0]) begin
					run_nxt = 1'b1;                 // [R10]
					rev_nxt = 1'b0;
				end else if (inRise[1]) begin
					run_nxt = 1'b1;                 // [R10]
					rev_nxt = 1'b1;
				end
			end
			sll_pkg::SCH_SINGLE: begin
				if (inRise[2]) begin
					run_nxt = 1'b0;                 // [R11]
				end else if (inRise[0]) begin
					run_nxt = 1'b1;                 // [R11]
					rev_nxt = run_r ? !rev_r : 1'b0;
				end else if (inRise[1]) begin
					run_nxt = 1'b1;                 // [R11]
					rev_nxt = run_r ? !rev_r : 1'b1;
				end
			end
			default: run_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			run_r  <= 1'b0;
			rev_r  <= 1'b0;
			step_r <= 1'b0;
			dir_r  <= 1'b0;
			stop_r <= 1'b0;
			stat_r <= 1'b0;
		end else begin
			run_r  <= run_nxt;
			rev_r  <= rev_nxt;
			step_r <= step_nxt;
			dir_r  <= dir_nxt;
			stop_r <= stop_nxt;
			stat_r <= stat_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign greenLed   = green_r;
	assign yellowLed  = yellow_r;
	assign learnStart = learnStart_r;
	assign busMode    = busMode_r;
	assign runEnable  = run_r;
	assign runReverse = rev_r;
	assign stepPulse  = step_r;
	assign stepDir    = dir_r;
	assign eStop      = stop_r;
	assign statusOut  = stat_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	slow_blink_a: assert property ( // [R1]
		(seq_r == sll_pkg::SEQ_IDLE && !faultActive && !commActive)
		|=> greenLed == $past(slowPh))
		else $error("green not on slow phase");
	fast_blink_a: assert property ( // [R2]
		(seq_r == sll_pkg::SEQ_IDLE && !faultActive && commActive)
		|=> greenLed == $past(fastPh))
		else $error("green not on fast phase");
	yellow_mode_a: assert property ( // [R3]
		(seq_r == sll_pkg::SEQ_IDLE && !faultActive && !busMode)
		|=> yellowLed)
		else $error("yellow dark in signal mode");
	yellow_dark_a: assert property ( // [R4]
		(seq_r == sll_pkg::SEQ_IDLE && !faultActive && busMode)
		|=> !yellowLed)
		else $error("yellow lit in bus mode");
	fault_lamp_a: assert property ( // [R5]
		(seq_r == sll_pkg::SEQ_IDLE && faultActive) |=> !greenLed)
		else $error("green lit during fault");
	learn_alt_a: assert property ( // [R13]
		(seq_r == sll_pkg::SEQ_ALT) |=> greenLed != yellowLed)
		else $error("lamps not alternating");
	learn_hold_a: assert property ( // [R6]
		(seq_r == sll_pkg::SEQ_HOLD) |=> (greenLed && yellowLed))
		else $error("both lamps not held");
	learn_fail_a: assert property ( // [R7]
		(seq_r == sll_pkg::SEQ_FAIL) |=> !greenLed)
		else $error("green lit in failure flashes");
	short_press_a: assert property ( // [R8]
		(btnFall && !longHeld) |=> learnStart ##1 !learnStart)
		else $error("short press did not start learning");
	long_press_a: assert property ( // [R9]
		(btnFall && longHeld) |=> (busMode && !learnStart))
		else $error("long press did not select bus mode");
	double_stop_a: assert property ( // [R10]
		(scheme == sll_pkg::SCH_DOUBLE && inRise[2]) |=> !runEnable)
		else $error("stop input ignored");
	single_flip_a: assert property ( // [R11]
		(scheme == sll_pkg::SCH_SINGLE && inRise[0] && !inRise[2]
		 && runEnable)
		|=> runReverse != $past(runReverse))
		else $error("single touch did not flip direction");
	step_pulse_a: assert property ( // [R12]
		(scheme == sll_pkg::SCH_POS && inRise[0] && !pinSync[2])
		|=> stepPulse ##1 !stepPulse)
		else $error("no single step pulse");

endmodule : sll_status_led

//--- dv/sll_operator_model.sv
// operator model: pushbutton with contact bounce and control switches
`timescale 1ns/10ps

module sll_operator_model #(
	parameter int MS_CYCLES = 4                 // cycles per ms tick
) (
	input  wire logic        clk,
	input  wire logic [15:0] pressMs,           // hold time of a press
	input  wire logic        pressGo,           // start one press
	input  wire logic        bounce,            // chatter before the hold
	input  wire logic [2:0]  ctrlLevel,         // wanted switch levels
	output logic             buttonPin,         // pressed = high
	output logic [2:0]       ctrlPin,           // switch contacts
	output logic             busy               // press under way
);

	// ------------------------------------------------------------
	// control switches
	// ------------------------------------------------------------
	// contacts follow the wanted level one edge later; open = pulled low
	always @(posedge clk) begin
		ctrlPin <= ctrlLevel;
	end

	// ------------------------------------------------------------
	// pushbutton
	// ------------------------------------------------------------
	// chatter is 1 ms wide so that a sane filter must reject it
	always begin
		buttonPin = 1'b0;
		busy      = 1'b0;
		forever begin
			@(posedge clk);
			if (pressGo === 1'b1) begin
				busy <= 1'b1;
				if (bounce === 1'b1) begin
					repeat (3) begin
						buttonPin <= 1'b1;
						repeat (MS_CYCLES) @(posedge clk);
						buttonPin <= 1'b0;
						repeat (MS_CYCLES) @(posedge clk);
					end
				end
				buttonPin <= 1'b1;
				repeat (int'(pressMs) * MS_CYCLES) @(posedge clk);
				buttonPin <= 1'b0;
				busy      <= 1'b0;
			end
		end
	end

endmodule : sll_operator_model

//--- dv/sll_status_led_bench.sv
// self-checking bench for the status lamp and learning sequencer
`timescale 1ns/10ps

module sll_status_led_bench;

	// ------------------------------------------------------------
	// timing; short ms tick keeps the run small
	// ------------------------------------------------------------
	localparam int T     = 4;                             // cycles per ms
	localparam int SLOW  = sll_pkg::SLOW_PERIOD_MS * T;   // slow period
	localparam int FAST  = sll_pkg::FAST_PERIOD_MS * T;   // fast period
	localparam int HALF  = sll_pkg::LEARN_HALF_MS * T;    // flash half
	localparam int WATCH = 97000;                         // hang limit

	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	logic                 buttonPin;
	logic [2:0]           ctrlPin;
	sll_pkg::sll_scheme_t scheme = sll_pkg::SCH_DOUBLE;
	logic                 commActive = 1'b0;
	logic                 faultActive = 1'b0;
	logic                 moveDone = 1'b0;
	logic                 learnDone = 1'b0;
	logic                 learnOk = 1'b0;
	logic                 greenLed, yellowLed, learnStart, busMode;
	logic                 runEnable, runReverse, stepPulse, stepDir, eStop;
	logic                 statusOut;
	logic [15:0]          pressMs = 16'h0000;   // operator requests
	logic                 pressGo = 1'b0;
	logic                 bounce = 1'b0;
	logic [2:0]           ctrlLevel = 3'h0;
	int                   mismatches = 0;
	int                   nCompared = 0;
	int                   cyc = 0;              // free cycle count
	int                   stepCount = 0;        // step pulses seen
	int                   runM = 0;             // model of the run state
	int                   revM = 0;
	int                   stepsM = 0;
	int                   seed = 15037;

	always #2.5 clk = ~clk;

	sll_status_led #(.MS_TICK_CYCLES(T)) dut (
		.clk(clk), .rst(rst), .buttonPin(buttonPin), .ctrlPin(ctrlPin),
		.scheme(scheme), .commActive(commActive),
		.faultActive(faultActive), .moveDone(moveDone),
		.learnDone(learnDone), .learnOk(learnOk), .greenLed(greenLed),
		.yellowLed(yellowLed), .learnStart(learnStart), .busMode(busMode),
		.runEnable(runEnable), .runReverse(runReverse),
		.stepPulse(stepPulse), .stepDir(stepDir), .eStop(eStop),
		.statusOut(statusOut)
	);

	sll_operator_model #(.MS_CYCLES(T)) operator (
		.clk(clk), .pressMs(pressMs), .pressGo(pressGo), .bounce(bounce),
		.ctrlLevel(ctrlLevel), .buttonPin(buttonPin), .ctrlPin(ctrlPin),
		.busy()
	);

	// cycle count; the bench reads it at falling edges, except learn, which reads t0 at a rising edge
	always @(posedge clk) begin
		cyc <= cyc + 1;
	end

	// step pulses tallied mid-cycle, where the pulse has settled
	always @(negedge clk) begin
		if (stepPulse === 1'b1) begin
			stepCount <= stepCount + 1;
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		if (mismatches == 0 && nCompared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	task automatic toCyc(input int t);
		while (cyc < t) @(negedge clk);
	endtask : toCyc

	// bounded wait for a green rising edge; returns its cycle
	task automatic waitRise(output int at);
		logic p;
		int   n;
		n = 0;
		p = greenLed;
		do begin
			@(negedge clk);
			n++;
			if (greenLed === 1'b1 && p === 1'b0) break;
			p = greenLed;
		end while (n < 20000);
		at = cyc;
	endtask : waitRise

	// green period between two rises
	task automatic period(input int exp);
		int a;
		int b;
		waitRise(a);
		waitRise(b);
		check(b - a, exp);
	endtask : period

	// result sequence, sampled in the middle of every half phase
	task automatic learn(input logic ok);
		int t0;
		int n;
		@(posedge clk);
		learnDone <= 1'b1;
		learnOk   <= ok;
		t0 = cyc;
		@(posedge clk);
		learnDone <= 1'b0;
		n = ok ? 16 : 18;
		for (int k = 0; k < n; k++) begin
			toCyc(t0 + HALF / 2 + HALF * k);
			if (k < 12) begin
				check({greenLed, yellowLed}, (k % 2 == 0) ? 2 : 1);
			end else if (ok) begin
				check({greenLed, yellowLed}, 3);
			end else begin
				check({greenLed, yellowLed}, (k % 2 == 0) ? 1 : 0);
			end
		end
		toCyc(t0 + HALF * n + 8);
	endtask : learn

	// one press; counts start pulses over a bounded window
	task automatic press(input int ms, input logic bn, input int exp);
		int starts;
		starts = 0;
		@(posedge clk);
		pressMs <= 16'(ms);
		bounce  <= bn;
		pressGo <= 1'b1;
		@(posedge clk);
		pressGo <= 1'b0;
		repeat ((ms + 60) * T + 100) begin
			@(negedge clk);
			if (learnStart === 1'b1) starts++;
		end
		check(starts, exp);
	endtask : press

	// one activation of a discrete input, then model against design
	task automatic hit(input int idx);
		@(posedge clk);
		ctrlLevel[idx] <= 1'b1;
		repeat (8) @(posedge clk);
		ctrlLevel[idx] <= 1'b0;
		repeat (8) @(posedge clk);
		if (scheme == sll_pkg::SCH_NONE) begin
			runM = 0;
		end else if (scheme == sll_pkg::SCH_POS) begin
			if (idx == 0 && ctrlLevel[2] !== 1'b1) stepsM++;
		end else if (idx == 2) begin
			runM = 0;
		end else if (scheme == sll_pkg::SCH_DOUBLE || runM == 0) begin
			runM = 1;
			revM = idx;
		end else begin
			revM = 1 - revM;
		end
		@(negedge clk);
		check(runEnable, runM);
		if (scheme != sll_pkg::SCH_POS) begin
			check(runReverse, revM);
		end
		check(stepCount, stepsM);
	endtask : hit

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int fallsY;
		int greenOn;
		repeat (5) @(posedge clk);
		@(negedge clk);
		check({greenLed, yellowLed, learnStart, busMode, runEnable,
			runReverse, stepPulse, stepDir, eStop, statusOut}, 0);
		@(posedge clk);
		rst <= 1'b0;
		repeat (20) @(negedge clk);
		check({yellowLed, busMode}, 2);
		period(SLOW);
		@(posedge clk);
		commActive <= 1'b1;
		period(FAST);
		check(yellowLed, 1);
		learn(1'b1);
		learn(1'b0);
		@(posedge clk);
		commActive  <= 1'b0;
		faultActive <= 1'b1;
		// one edge for the lamps to take up the fault pattern
		@(posedge clk);
		fallsY  = 0;
		greenOn = 0;
		repeat (SLOW + 20) begin
			@(negedge clk);
			if (greenLed === 1'b1) greenOn++;
			if (yellowLed === 1'b0) fallsY++;
		end
		check({greenOn == 0, fallsY > 0, fallsY < SLOW}, 3'h7);
		@(posedge clk);
		faultActive <= 1'b0;
		press(100, 1'b1, 1);
		press(5, 1'b0, 0);
		check(busMode, 0);
		press(1200, 1'b0, 0);
		check(busMode, 1);
		repeat (20) @(negedge clk);
		check(yellowLed, 0);
		period(SLOW);
		for (int v = 0; v < 4; v++) begin
			@(posedge clk);
			faultActive <= v[0];
			moveDone    <= v[1];
			repeat (4) @(negedge clk);
			check(statusOut, v[0] | v[1]);
		end
		@(posedge clk);
		faultActive <= 1'b0;
		moveDone    <= 1'b0;
		hit(0); hit(1); hit(2); hit(1); hit(0); hit(2);
		@(posedge clk);
		scheme <= sll_pkg::SCH_SINGLE;
		repeat (14) hit({$random(seed)} % 3);
		hit(2);
		@(posedge clk);
		scheme <= sll_pkg::SCH_POS;
		repeat (10) begin
			@(posedge clk);
			ctrlLevel[1] <= 1'($random(seed));
			ctrlLevel[2] <= ({$random(seed)} % 4 == 0);
			repeat (6) @(posedge clk);
			hit(0);
			check({eStop, stepDir}, ctrlLevel[2:1]);
		end
		// unused scheme: an input activation must not start the motor
		@(posedge clk);
		scheme <= sll_pkg::SCH_NONE;
		hit(0);
		stop_test();
	end

	// hang guard: a run that overstays counts as a failure
	initial begin
		repeat (WATCH) @(posedge clk);
		mismatches++;
		stop_test();
	end

endmodule : sll_status_led_bench
